// File: core/sie_pkg.sv
// Constants, types and helpers of the safety input evaluator
//
// Overview of operation
// - Each connector: channels A, B, two test outputs
// - Equivalent pair: Active 11, Inactive 00
// - Complementary pair: Active A1 B0, Inactive A0 B1
// - Slope check only on single channels, rising edges
// - Slope check delays reaction, uses test output
// - Dual result always goes to A position
// - B reporting enabled publishes B channel value
// - B reporting disabled forces B bit zero
// - Rising uses OFF-ON delay, falling ON-OFF delay
// - Delays 0 to 635 ms, 5 ms steps
// - Every channel keeps its own delay settings
// - Discrepancy time 0 to 30000 ms per pair
// - One global latch time holds every input error
// - Latched error clears only when condition gone
// - Latch time resets to 1000 ms, max 65535
// - Timer starts at first change, then checks pattern
// - Discrepancy error clears once pair is Inactive
package sie_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_NS       = 1000000;
	localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY_STEP_MS   = 5;
	localparam int unsigned DLY_W         = 7;
	localparam logic [1:0]  SLOPE_TICKS   = 2'h2;
	localparam logic [15:0] LATCH_RST_MS  = 16'h03e8;
	localparam logic [15:0] DISC_MAX_MS   = 16'h7530;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] REG_GLOBAL    = 8'h00;
	localparam logic [7:0] REG_IMAGE     = 8'h04;
	localparam logic [7:0] REG_ERR       = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT  = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
	localparam logic [7:0] REG_PAIR_BASE = 8'h20;
	localparam logic [7:0] REG_DLY_BASE  = 8'h40;
	localparam int unsigned PCF_MODE_LSB = 0;
	localparam int unsigned PCF_SLOPE_A  = 2;
	localparam int unsigned PCF_SLOPE_B  = 3;
	localparam int unsigned PCF_BREP     = 4;
	localparam int unsigned PCF_DISC_LSB = 16;
	localparam int unsigned DLY_ON_LSB   = 0;
	localparam int unsigned DLY_OFF_LSB  = 8;
	localparam int unsigned ERR_COND_LSB = 8;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		SIE_SINGLE = 2'h0,
		SIE_EQUIV  = 2'h1,
		SIE_COMPL  = 2'h2
	} sie_mode_t;

	typedef enum logic [4:0] {
		SIE_P_IDLE  = 5'h01,
		SIE_P_WAIT  = 5'h02,
		SIE_P_ACT   = 5'h04,
		SIE_P_BLOCK = 5'h08,
		SIE_P_ERR   = 5'h10
	} sie_pair_st_t;

	typedef enum logic [3:0] {
		SIE_S_IDLE = 4'h1,
		SIE_S_TEST = 4'h2,
		SIE_S_PASS = 4'h4,
		SIE_S_FAIL = 4'h8
	} sie_slope_st_t;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [9:0] sie_steps_ms(input logic [DLY_W-1:0] s);
		return 10'(s * DLY_STEP_MS);
	endfunction : sie_steps_ms

	function automatic logic [7:0] sie_word_addr(input logic [7:0] base,
		input int unsigned idx);
		return base + 8'(idx * 4);
	endfunction : sie_word_addr

endpackage : sie_pkg

// File: core/sie_chan_filter.sv
// Per-channel slope check and OFF-ON / ON-OFF input delay
module sie_chan_filter (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_ce,
	input  wire logic                      i_tick,
	input  wire logic                      i_raw,
	input  wire logic [sie_pkg::DLY_W-1:0] i_on_steps,
	input  wire logic [sie_pkg::DLY_W-1:0] i_off_steps,
	input  wire logic                      i_slope_en,
	output logic                           o_level,
	output logic                           o_test,
	output logic                           o_slope_err
);

	sie_pkg::sie_slope_st_t st_reg;
	logic [1:0]             scnt_reg;
	logic                   qual;
	logic [9:0]             cnt_reg;
	logic [9:0]             tgt;

	// ****************************************************************
	// Slope check
	// ****************************************************************
	always_comb begin
		if (i_slope_en) begin
			qual = (st_reg == sie_pkg::SIE_S_PASS) && i_raw;
		end else begin
			qual = i_raw;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st_reg      <= sie_pkg::SIE_S_IDLE;
			scnt_reg    <= 2'h0;
			o_test      <= 1'b1;
			o_slope_err <= 1'b0;
		end else if (i_ce) begin
			if (!i_slope_en) begin
				st_reg      <= sie_pkg::SIE_S_IDLE;
				scnt_reg    <= 2'h0;
				o_test      <= 1'b1;
				o_slope_err <= 1'b0;
			end else begin
				unique case (st_reg)
					sie_pkg::SIE_S_IDLE: begin
						if (i_raw) begin
							st_reg   <= sie_pkg::SIE_S_TEST;
							o_test   <= 1'b0;
							scnt_reg <= 2'h0;
						end
					end
					sie_pkg::SIE_S_TEST: begin
						if (i_tick) begin
							if (scnt_reg == sie_pkg::SLOPE_TICKS - 2'h1) begin
								o_test   <= 1'b1;
								scnt_reg <= 2'h0;
								if (i_raw) begin
									st_reg      <= sie_pkg::SIE_S_FAIL;
									o_slope_err <= 1'b1;
								end else begin
									st_reg <= sie_pkg::SIE_S_PASS;
								end
							end else begin
								scnt_reg <= scnt_reg + 2'h1;
							end
						end
					end
					sie_pkg::SIE_S_PASS: begin
						// Guard one tick while the input recovers
						if (scnt_reg == 2'h0) begin
							if (i_tick) begin
								scnt_reg <= 2'h1;
							end
						end else if (!i_raw) begin
							st_reg <= sie_pkg::SIE_S_IDLE;
						end
					end
					sie_pkg::SIE_S_FAIL: begin
						if (!i_raw) begin
							st_reg      <= sie_pkg::SIE_S_IDLE;
							o_slope_err <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Input delay
	// ****************************************************************
	always_comb begin
		tgt = qual ? sie_pkg::sie_steps_ms(i_on_steps)
			: sie_pkg::sie_steps_ms(i_off_steps);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_level <= 1'b0;
			cnt_reg <= 10'h000;
		end else if (i_ce) begin
			if (qual == o_level) begin
				cnt_reg <= 10'h000;
			end else if (tgt == 10'h000) begin
				o_level <= qual;
			end else if (i_tick) begin
				if (cnt_reg + 10'h001 >= tgt) begin
					o_level <= qual;
					cnt_reg <= 10'h000;
				end else begin
					cnt_reg <= cnt_reg + 10'h001;
				end
			end
		end
	end

endmodule : sie_chan_filter

// File: core/sie_top.sv
// Safety input evaluator: pairing, discrepancy, error latch, registers
module sie_top #(
	parameter int unsigned N_CONN   = 6,
	parameter int unsigned TICK_CYC = sie_pkg::TICK_CYC
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_ce,
	input  wire logic [2*N_CONN-1:0]   i_in,
	output logic      [2*N_CONN-1:0]   o_test,
	output logic      [2*N_CONN-1:0]   o_image,
	output logic      [N_CONN-1:0]     o_err,
	output logic                       o_irq,
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [31:0]           o_rdata
);

	localparam int unsigned N_CH  = 2 * N_CONN;
	localparam int unsigned TCK_W = $clog2(TICK_CYC);

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	generate
		if (N_CONN < 1 || N_CONN > 8 || TICK_CYC < 2) begin : g_bad
			$error("sie_top: unsupported N_CONN or TICK_CYC");
		end
	endgenerate

	logic [N_CH-1:0]          in_meta_reg;
	logic [N_CH-1:0]          in_sync_reg;
	logic [TCK_W-1:0]         tick_cnt_reg;
	logic                     tick_reg;
	logic [15:0]              latch_ms_reg;
	sie_pkg::sie_mode_t       mode_reg [N_CONN];
	logic [1:0]               slope_reg [N_CONN];
	logic                     brep_reg [N_CONN];
	logic [15:0]              disc_reg [N_CONN];
	logic [sie_pkg::DLY_W-1:0] on_reg [N_CH];
	logic [sie_pkg::DLY_W-1:0] off_reg [N_CH];
	logic [7:0]               mask_reg;
	logic [7:0]               stat_reg;
	logic [7:0]               stat_next;
	logic [N_CH-1:0]          filt;
	logic [N_CH-1:0]          serr;
	sie_pkg::sie_pair_st_t    pst_reg [N_CONN];
	logic [15:0]              dcnt_reg [N_CONN];
	logic [N_CONN-1:0]        cond;
	logic [N_CONN-1:0]        lat_reg;
	logic [15:0]              lcnt_reg [N_CONN];
	logic [31:0]              rd_val;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic pair_act(input sie_pkg::sie_mode_t m,
		input logic a, input logic b);
		return (m == sie_pkg::SIE_COMPL) ? (a && !b) : (a && b);
	endfunction : pair_act

	function automatic logic pair_inact(input sie_pkg::sie_mode_t m,
		input logic a, input logic b);
		return (m == sie_pkg::SIE_COMPL) ? (!a && b) : (!a && !b);
	endfunction : pair_inact

	// ****************************************************************
	// Input synchroniser
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			in_meta_reg <= '0;
			in_sync_reg <= '0;
		end else if (i_ce) begin
			in_meta_reg <= i_in;
			in_sync_reg <= in_meta_reg;
		end
	end

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (i_ce) begin
			if (tick_cnt_reg == TCK_W'(TICK_CYC - 1)) begin
				tick_cnt_reg <= '0;
				tick_reg     <= 1'b1;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + TCK_W'(1);
				tick_reg     <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			latch_ms_reg <= sie_pkg::LATCH_RST_MS;
			mask_reg     <= 8'h00;
			for (int k = 0; k < N_CONN; k++) begin
				mode_reg[k]  <= sie_pkg::SIE_SINGLE;
				slope_reg[k] <= 2'h0;
				brep_reg[k]  <= 1'b0;
				disc_reg[k]  <= 16'h0000;
			end
			for (int c = 0; c < N_CH; c++) begin
				on_reg[c]  <= '0;
				off_reg[c] <= '0;
			end
		end else if (i_ce && i_wr) begin
			if (i_addr == sie_pkg::REG_GLOBAL) begin
				latch_ms_reg <= i_wdata[15:0];
			end
			if (i_addr == sie_pkg::REG_IRQ_MASK) begin
				mask_reg <= i_wdata[7:0];
			end
			for (int k = 0; k < N_CONN; k++) begin
				if (i_addr == sie_pkg::sie_word_addr(sie_pkg::REG_PAIR_BASE,
					k)) begin
					if (i_wdata[sie_pkg::PCF_MODE_LSB +: 2] == 2'h3) begin
						mode_reg[k] <= sie_pkg::SIE_SINGLE;
					end else begin
						mode_reg[k] <= sie_pkg::sie_mode_t'(
							i_wdata[sie_pkg::PCF_MODE_LSB +: 2]);
					end
					slope_reg[k] <= {i_wdata[sie_pkg::PCF_SLOPE_B],
						i_wdata[sie_pkg::PCF_SLOPE_A]};
					brep_reg[k]  <= i_wdata[sie_pkg::PCF_BREP];
					if (i_wdata[sie_pkg::PCF_DISC_LSB +: 16] >
						sie_pkg::DISC_MAX_MS) begin
						disc_reg[k] <= sie_pkg::DISC_MAX_MS;
					end else begin
						disc_reg[k] <= i_wdata[sie_pkg::PCF_DISC_LSB +: 16];
					end
				end
			end
			for (int c = 0; c < N_CH; c++) begin
				if (i_addr == sie_pkg::sie_word_addr(sie_pkg::REG_DLY_BASE,
					c)) begin
					on_reg[c]  <= i_wdata[sie_pkg::DLY_ON_LSB +:
						sie_pkg::DLY_W];
					off_reg[c] <= i_wdata[sie_pkg::DLY_OFF_LSB +:
						sie_pkg::DLY_W];
				end
			end
		end
	end

	// ****************************************************************
	// Channel filters
	// ****************************************************************
	generate
		for (genvar c = 0; c < N_CH; c++) begin : g_ch
			sie_chan_filter u_filt (
				.i_sys_clk   (i_sys_clk),
				.i_rst_n     (i_rst_n),
				.i_ce        (i_ce),
				.i_tick      (tick_reg),
				.i_raw       (in_sync_reg[c]),
				.i_on_steps  (on_reg[c]),
				.i_off_steps (off_reg[c]),
				.i_slope_en  (slope_reg[c/2][c%2] &&
					mode_reg[c/2] == sie_pkg::SIE_SINGLE),
				.o_level     (filt[c]),
				.o_test      (o_test[c]),
				.o_slope_err (serr[c])
			);
		end
	endgenerate

	// ****************************************************************
	// Dual-channel discrepancy state
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			for (int k = 0; k < N_CONN; k++) begin
				pst_reg[k]  <= sie_pkg::SIE_P_IDLE;
				dcnt_reg[k] <= 16'h0000;
			end
		end else if (i_ce) begin
			for (int k = 0; k < N_CONN; k++) begin
				if (mode_reg[k] == sie_pkg::SIE_SINGLE) begin
					pst_reg[k]  <= sie_pkg::SIE_P_IDLE;
					dcnt_reg[k] <= 16'h0000;
				end else begin
					unique case (pst_reg[k])
						sie_pkg::SIE_P_IDLE: begin
							dcnt_reg[k] <= 16'h0000;
							if (pair_act(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_ACT;
							end else if (!pair_inact(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_WAIT;
							end
						end
						sie_pkg::SIE_P_WAIT: begin
							if (pair_act(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_ACT;
							end else if (pair_inact(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_IDLE;
							end else if (tick_reg && disc_reg[k] != 16'h0000)
								begin
								if (dcnt_reg[k] + 16'h0001 >= disc_reg[k]) begin
									pst_reg[k] <= sie_pkg::SIE_P_ERR;
								end else begin
									dcnt_reg[k] <= dcnt_reg[k] + 16'h0001;
								end
							end
						end
						sie_pkg::SIE_P_ACT: begin
							if (pair_inact(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_IDLE;
							end else if (!pair_act(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_BLOCK;
							end
						end
						sie_pkg::SIE_P_BLOCK: begin
							if (pair_inact(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_IDLE;
							end
						end
						sie_pkg::SIE_P_ERR: begin
							if (pair_inact(mode_reg[k], filt[2*k],
								filt[2*k+1])) begin
								pst_reg[k] <= sie_pkg::SIE_P_IDLE;
							end
						end
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// Process image
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_image <= '0;
		end else if (i_ce) begin
			for (int k = 0; k < N_CONN; k++) begin
				if (mode_reg[k] == sie_pkg::SIE_SINGLE) begin
					o_image[2*k]   <= filt[2*k];
					o_image[2*k+1] <= filt[2*k+1];
				end else begin
					o_image[2*k]   <= (pst_reg[k] == sie_pkg::SIE_P_ACT);
					o_image[2*k+1] <= brep_reg[k] ? filt[2*k+1]
						: 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Error latch
	// ****************************************************************
	always_comb begin
		for (int k = 0; k < N_CONN; k++) begin
			cond[k] = (pst_reg[k] == sie_pkg::SIE_P_ERR) || serr[2*k] ||
				serr[2*k+1];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			lat_reg <= '0;
			for (int k = 0; k < N_CONN; k++) begin
				lcnt_reg[k] <= 16'h0000;
			end
		end else if (i_ce) begin
			for (int k = 0; k < N_CONN; k++) begin
				if (cond[k]) begin
					lat_reg[k]  <= 1'b1;
					lcnt_reg[k] <= 16'h0000;
				end else if (lat_reg[k]) begin
					if (lcnt_reg[k] >= latch_ms_reg) begin
						lat_reg[k] <= 1'b0;
					end else if (tick_reg) begin
						lcnt_reg[k] <= lcnt_reg[k] + 16'h0001;
					end
				end
			end
		end
	end

	assign o_err = lat_reg;

	// ****************************************************************
	// Interrupt
	// ****************************************************************
	always_comb begin
		stat_next = stat_reg;
		if (i_wr && i_addr == sie_pkg::REG_IRQ_STAT) begin
			stat_next = stat_next & ~i_wdata[7:0];
		end
		stat_next = stat_next | 8'(cond & ~lat_reg);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			stat_reg <= 8'h00;
			o_irq    <= 1'b0;
		end else if (i_ce) begin
			stat_reg <= stat_next;
			o_irq    <= |(stat_next & mask_reg);
		end
	end

	// ****************************************************************
	// Register read
	// ****************************************************************
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (i_addr)
			sie_pkg::REG_GLOBAL:   rd_val = {16'h0000, latch_ms_reg};
			sie_pkg::REG_IMAGE:    rd_val = 32'(o_image);
			sie_pkg::REG_ERR:      rd_val = 32'(lat_reg) |
				(32'(cond) << sie_pkg::ERR_COND_LSB);
			sie_pkg::REG_IRQ_STAT: rd_val = {24'h000000, stat_reg};
			sie_pkg::REG_IRQ_MASK: rd_val = {24'h000000, mask_reg};
			default: begin
				for (int k = 0; k < N_CONN; k++) begin
					if (i_addr == sie_pkg::sie_word_addr(sie_pkg::REG_PAIR_BASE,
						k)) begin
						rd_val = (32'(disc_reg[k]) << sie_pkg::PCF_DISC_LSB) |
							(32'(brep_reg[k]) << sie_pkg::PCF_BREP) |
							(32'(slope_reg[k]) << sie_pkg::PCF_SLOPE_A) |
							32'(mode_reg[k]);
					end
				end
				for (int c = 0; c < N_CH; c++) begin
					if (i_addr == sie_pkg::sie_word_addr(sie_pkg::REG_DLY_BASE,
						c)) begin
						rd_val = (32'(off_reg[c]) << sie_pkg::DLY_OFF_LSB) |
							32'(on_reg[c]);
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			o_rdata <= i_rd ? rd_val : 32'h0000_0000;
		end
	end

endmodule : sie_top

// File: dv/sie_checker.sv
// Port checker of the safety input evaluator, bound to the top module
module sie_checker #(
	parameter int unsigned N_CONN   = 6,
	parameter int unsigned TICK_CYC = 10
) (
	input wire logic                i_sys_clk,
	input wire logic                i_rst_n,
	input wire logic                i_ce,
	input wire logic [2*N_CONN-1:0] i_in,
	input wire logic [2*N_CONN-1:0] o_test,
	input wire logic [2*N_CONN-1:0] o_image,
	input wire logic [N_CONN-1:0]   o_err,
	input wire logic                o_irq,
	input wire logic [7:0]          i_addr,
	input wire logic [31:0]         i_wdata,
	input wire logic                i_wr,
	input wire logic                i_rd,
	input wire logic [31:0]         o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0]  cfg_reg;
	logic [1:0]  dly_reg;
	logic        mask_reg;
	logic [15:0] lat_reg;
	logic [3:0]  age_reg;
	logic [31:0] held_reg;
	logic        calm;
	assign calm = age_reg > 4'h8 && dly_reg == 2'h0;
	// ****
	// Shadow of connector 0 settings
	// ****
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cfg_reg <= 5'h00;
			dly_reg <= 2'h0;
			mask_reg <= 1'b0;
			lat_reg <= sie_pkg::LATCH_RST_MS;
			age_reg <= 4'h0;
		end else begin
			age_reg <= (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
			if (i_wr && i_addr == 8'h20) cfg_reg <= i_wdata[4:0];
			if (i_wr && i_addr[7:3] == 5'h08)
				dly_reg[i_addr[2]] <= |{i_wdata[14:8], i_wdata[6:0]};
			if (i_wr && i_addr == 8'h10) mask_reg <= i_wdata[0];
			if (i_wr && i_addr == 8'h00) lat_reg <= i_wdata[15:0];
			if (!i_ce || (i_wr && (i_addr == 8'h20 ||
				i_addr[7:3] == 5'h08)))
				age_reg <= 4'h0;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !o_err[0]) held_reg <= 32'h0;
		else held_reg <= held_reg + 32'h1;
	end
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	AST_RST_DEF: assert property (disable iff (1'b0)
		!i_rst_n |=> o_test == '1 && o_image == '0 && o_err == '0 && !o_irq)
		else $error("outputs not at reset values");
	AST_SINGLE: assert property (calm && cfg_reg[2:0] == 3'h0
		|-> o_image[0] == $past(i_in[0], 4)) else $error("single latency");
	AST_EQUIV: assert property (calm && cfg_reg[1:0] == 2'h1
		&& !($past(i_in[0], 5) && $past(i_in[1], 5)) |-> !o_image[0])
		else $error("equivalent pair active wrongly");
	AST_COMPL: assert property (calm && cfg_reg[1:0] == 2'h2
		&& !($past(i_in[0], 5) && !$past(i_in[1], 5)) |-> !o_image[0])
		else $error("complementary pair active wrongly");
	AST_BREP_ON: assert property (calm && cfg_reg[1:0] != 2'h0 && cfg_reg[4]
		|-> o_image[1] == $past(i_in[1], 4)) else $error("B bit not shown");
	AST_BREP_OFF: assert property (calm && cfg_reg[1:0] != 2'h0
		&& !cfg_reg[4] |-> !o_image[1]) else $error("B bit not zero");
	AST_DUAL_TEST: assert property (calm && cfg_reg[1:0] != 2'h0
		|-> o_test[1:0] == 2'h3) else $error("slope test on dual pair");
	AST_LATCH: assert property ($fell(o_err[0]) && lat_reg != 16'h0
		|-> held_reg >= 32'(lat_reg - 16'h1) * TICK_CYC)
		else $error("error released before latch time");
	AST_IRQ: assert property ($rose(o_err[0]) && mask_reg
		|-> ##[0:2] o_irq) else $error("no interrupt on error");
	COV_ERR: cover property (o_err[0]);
	COV_IRQ: cover property ($fell(o_irq));
	COV_SLOPE: cover property ($fell(o_test[4]));
endmodule : sie_checker

bind sie_top sie_checker #(.N_CONN(N_CONN), .TICK_CYC(TICK_CYC)) u_chk (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_in(i_in),
	.o_test(o_test), .o_image(o_image), .o_err(o_err), .o_irq(o_irq),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata));

// File: dv/sie_field.sv
// Field contacts and sensors in front of the input pins
module sie_field #(
	parameter int unsigned N = 12
) (
	input  wire logic         i_sys_clk,
	input  wire logic [N-1:0] i_level,
	input  wire logic [N-1:0] i_stuck,
	input  wire logic [N-1:0] i_bounce,
	input  wire logic [N-1:0] i_test,
	output logic      [N-1:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [N-1:0] last_reg = '0;
	logic [2:0]   bcnt_reg [N] = '{default: 3'h0};
	// Contact bounce after each change on channels with i_bounce set
	always_ff @(posedge i_sys_clk) begin
		for (int c = 0; c < N; c++) begin
			last_reg[c] <= i_level[c];
			if (i_bounce[c] && last_reg[c] != i_level[c]) bcnt_reg[c] <= 3'h6;
			else if (bcnt_reg[c] != 3'h0) bcnt_reg[c] <= bcnt_reg[c] - 3'h1;
		end
	end
	// Contact fed from its test output
	always_comb begin
		for (int c = 0; c < N; c++)
			o_pin[c] = i_stuck[c] | (i_test[c] & (i_level[c] ^ bcnt_reg[c][0]));
	end
endmodule : sie_field

// File: dv/sie_top_test.sv
// Self-checking bench of the safety input evaluator
module sie_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned TICK = 10;
	logic        clk;
	logic        rst_n = 1'b0;
	logic [11:0] level = '0;
	logic [11:0] stuck = '0;
	logic [11:0] bounce = '0;
	logic [11:0] pins;
	logic [11:0] test;
	logic [11:0] image;
	logic [5:0]  err;
	logic        irq;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] rdata;
	logic [31:0] seed = 32'h97610e56;
	logic [1:0]  mode = 2'h0;
	logic        brep = 1'b0;
	int          num_errors = 0;
	int          compares = 0;

	sie_field #(.N(12)) u_field (.i_sys_clk(clk), .i_level(level),
		.i_stuck(stuck), .i_bounce(bounce), .i_test(test), .o_pin(pins));
	sie_top #(.N_CONN(6), .TICK_CYC(TICK)) u_dut (.i_sys_clk(clk),
		.i_rst_n(rst_n), .i_ce(ce), .i_in(pins), .o_test(test),
		.o_image(image), .o_err(err), .o_irq(irq), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic pair_act(input logic [1:0] m, input logic [1:0] ab);
		return (m == 2'h1) ? &ab : (ab == 2'b01);
	endfunction : pair_act
	function automatic int dly_cyc(input int steps);
		return steps * sie_pkg::DLY_STEP_MS * TICK;
	endfunction : dly_cyc
	task automatic print_verdict();
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
		cyc(1);
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		#1 check(rdata, exp);
		cyc(1);
	endtask : rd_chk
	task automatic pin_img(input logic [1:0] v, input int n, input logic blk);
		level[1:0] <= v;
		cyc(n);
		check(image[1:0], {brep & v[1], pair_act(mode, v) & !blk});
	endtask : pin_img
	task automatic edge_dly(input logic v, input int d);
		level[2] <= v;
		cyc(dly_cyc(d) - TICK - 2);
		check(image[2], !v);
		cyc(TICK + 22);
		check(image[2], v);
	endtask : edge_dly

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		cyc(20000);
		num_errors++;
		print_verdict();
	end
	initial begin
		cyc(12);
		rst_n <= 1'b1;
		cyc(1);
		check(test, 32'hfff);
		rd_chk(8'h00, 32'h3e8);
		rd_chk(8'h80, 32'h0);
		wr_reg(8'h00, 32'hffff);
		rd_chk(8'h00, 32'hffff);
		wr_reg(8'h24, 32'hffff0003);
		rd_chk(8'h24, 32'h75300000);
		wr_reg(8'h00, 32'h14);
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			level <= seed[11:0];
			cyc(6);
			check(image, level);
		end
		rd_chk(8'h04, {20'h0, level});
		ce <= 1'b0;
		level <= ~level;
		cyc(8);
		check(image, {20'h0, ~level});
		ce <= 1'b1;
		cyc(6);
		check(image, level);
		level <= '0;
		cyc(6);
		wr_reg(8'h48, 32'h0102);
		bounce[2] <= 1'b1;
		level[3] <= 1'b1;
		edge_dly(1'b1, 2);
		check(image[3], 1'b1);
		edge_dly(1'b0, 1);
		wr_reg(8'h10, 32'h1);
		wr_reg(8'h20, 32'h000a0001);
		mode = 2'h1;
		pin_img(2'b11, 150, 1'b0);
		pin_img(2'b01, 10, 1'b0);
		pin_img(2'b11, 150, 1'b1);
		pin_img(2'b00, 10, 1'b0);
		pin_img(2'b01, 50, 1'b0);
		pin_img(2'b11, 150, 1'b0);
		check(err[0], 1'b0);
		pin_img(2'b00, 10, 1'b0);
		pin_img(2'b10, 150, 1'b0);
		check(err[0], 1'b1);
		check(irq, 1'b1);
		rd_chk(8'h0c, 32'h1);
		wr_reg(8'h0c, 32'h1);
		cyc(2);
		check(irq, 1'b0);
		pin_img(2'b11, 400, 1'b1);
		check(err[0], 1'b1);
		pin_img(2'b00, 100, 1'b0);
		check(err[0], 1'b1);
		cyc(150);
		check(err[0], 1'b0);
		wr_reg(8'h20, 32'h12);
		mode = 2'h2;
		brep = 1'b1;
		pin_img(2'b10, 10, 1'b0);
		pin_img(2'b01, 10, 1'b0);
		pin_img(2'b11, 10, 1'b0);
		pin_img(2'b10, 10, 1'b0);
		wr_reg(8'h28, 32'h4);
		level[4] <= 1'b1;
		for (int i = 0; i < 50 && test[4] !== 1'b0; i++)
			cyc(1);
		check(test[4], 1'b0);
		cyc(40);
		check(image[4], 1'b1);
		level[4] <= 1'b0;
		cyc(40);
		stuck[4] <= 1'b1;
		level[4] <= 1'b1;
		cyc(50);
		check(err[2], 1'b1);
		stuck[4] <= 1'b0;
		level[4] <= 1'b0;
		cyc(300);
		check(err[2], 1'b0);
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		rd_chk(8'h28, 32'h0);
		rd_chk(8'h00, 32'h3e8);
		print_verdict();
	end
endmodule : sie_top_test
